//--- hdl/ubws_regs.vh
// Purpose: Register offsets, field positions, reset values and counts for the serial port.
// Assumes: APB byte addresses, one register to an aligned 32-bit word.
// Notes: Header of definitions only; included by its bare name.
`ifndef UBWS_REGS_VH
`define UBWS_REGS_VH

// Register byte offsets.
`define UBWS_OFF_CTRL 8'h00
`define UBWS_OFF_STAT 8'h04
`define UBWS_OFF_DIV 8'h08
`define UBWS_OFF_TXD 8'h0C
`define UBWS_OFF_RXD 8'h10

// Control register field positions.
`define UBWS_C_PEN 0
`define UBWS_C_SYNC 1
`define UBWS_C_CLOCK_SOURCE_MASTER 2
`define UBWS_C_TRANSMIT_ENABLE 3
`define UBWS_C_BREAK_SEND_REQUEST 4
`define UBWS_C_SINGLE_RECEIVE_ENABLE 5
`define UBWS_C_CONTINUOUS_RECEIVE_ENABLE 6
`define UBWS_C_WUE 7
`define UBWS_C_AUTOBAUD_ENABLE 8
`define UBWS_C_CKP 9
`define UBWS_C_DTP 10
`define UBWS_CTRL_W 11

// Status register field positions.
`define UBWS_S_ABOVF 0
`define UBWS_S_RXPEND 1
`define UBWS_S_FRAMING_ERROR_FLAG 2
`define UBWS_S_SHIFT_REG_EMPTY 3
`define UBWS_S_TXBE 4
`define UBWS_S_RIDLE 5

// Reset values.
`define UBWS_CTRL_RST 11'h000
`define UBWS_DIV_RST 16'h000F

// Counts: rate measurement prescale, rising edges of the sync byte, bit counts.
`define UBWS_AB_PRE_LAST 3'h7
`define UBWS_AB_EDGES 3'h5
`define UBWS_DATA_BITS 4'h8
`define UBWS_BRK_BITS 4'hC

`endif

//--- hdl/ubws_sync.v
// Purpose: Two-stage synchroniser for a level that arrives from outside the pclk domain.
// Assumes: Clock enable freezes both stages like all other state.
// Notes: Only the second stage is visible to the rest of the block.
`timescale 1ns/1ps
module ubws_sync (
    // Clock and reset.
    input wire pclk,
    input wire presetn,
    input wire clk_en,
    // Level in and synchronised level out.
    input wire async_in,
    output reg sync_out
);
    reg meta_r;

    // The first stage feeds only the second stage; idle level of the line is high.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_r <= 1'b1;
            sync_out <= 1'b1;
        end else if (clk_en) begin
            meta_r <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule

//--- hdl/ubws_top.v
// Purpose: Serial port with rate measurement, break wake-up, break send and sync master transmit.
// Assumes: pclk at 200 MHz; one async bit time is divisor plus one pclk cycles, a sync master bit twice that.
// Notes: Sync master reception and slave clocking are not built; the data pin is split into in/out/oe, the clock pin into out/oe.
//
// Decided for this implementation: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`include "ubws_regs.vh"
module ubws_top (
    // Clock, reset and clock enable.
    input wire pclk,
    input wire presetn,
    input wire clk_en,
    // APB slave.
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // Data pin, split into input, output and output enable.
    input wire rx_data_in,
    output reg rx_data_out,
    output reg rx_data_oe,
    // Transmit or shift clock pin, output side.
    output reg tx_clock_out,
    output reg tx_clock_oe
);
    // Transmit states.
    localparam TX_IDLE = 3'h0;
    localparam TX_START = 3'h1;
    localparam TX_DATA = 3'h2;
    localparam TX_STOP = 3'h3;
    localparam TX_SLEAD = 3'h4;
    localparam TX_STRAIL = 3'h5;
    // Receive states.
    localparam RX_IDLE = 3'h0;
    localparam RX_WAKE = 3'h1;
    localparam RX_ABWAIT = 3'h2;
    localparam RX_ABCNT = 3'h3;
    localparam RX_START = 3'h4;
    localparam RX_DATA = 3'h5;
    localparam RX_STOP = 3'h6;

    reg [`UBWS_CTRL_W-1:0] ctrl_r;
    reg [15:0] divisor_r;
    reg [7:0] txbuf_r;
    reg txbuf_vld_r;
    reg [2:0] tx_state_r;
    reg [15:0] tx_cnt_r;
    reg [3:0] tx_bits_r;
    reg [7:0] tsr_r;
    reg tx_brk_r;
    reg tx_line_r;
    reg clk_act_r;
    reg brk_clr_r;
    reg [2:0] rx_state_r;
    reg [15:0] rx_cnt_r;
    reg [3:0] rx_bits_r;
    reg [7:0] rsr_r;
    reg [7:0] rx_data_r;
    reg rx_pend_r;
    reg framing_error_flag_r;
    reg ab_ovf_r;
    reg [16:0] ab_cnt_r;
    reg [2:0] ab_pre_r;
    reg [2:0] ab_edges_r;
    reg ab_load_r;
    reg ab_clr_r;
    reg wue_clr_r;
    reg rx_prev_r;
    wire rx_pin_s;

    // Polarity applied to a data level in either direction.
    function pol;
        input d;
        input inv;
        begin
            pol = d ^ inv;
        end
    endfunction

    // True when a bit-time counter has reached the divisor.
    function bit_end;
        input [15:0] cnt;
        input [15:0] div;
        begin
            bit_end = (cnt == div);
        end
    endfunction

    // Control fields.
    wire pen = ctrl_r[`UBWS_C_PEN];
    wire sync_mode = ctrl_r[`UBWS_C_SYNC];
    wire clock_source_master = ctrl_r[`UBWS_C_CLOCK_SOURCE_MASTER];
    wire transmit_enable = ctrl_r[`UBWS_C_TRANSMIT_ENABLE];
    wire break_send_request = ctrl_r[`UBWS_C_BREAK_SEND_REQUEST];
    wire rx_any_en = ctrl_r[`UBWS_C_SINGLE_RECEIVE_ENABLE] | ctrl_r[`UBWS_C_CONTINUOUS_RECEIVE_ENABLE];
    wire wake_on_break_enable = ctrl_r[`UBWS_C_WUE];
    wire autobaud_enable = ctrl_r[`UBWS_C_AUTOBAUD_ENABLE];
    wire ckp = ctrl_r[`UBWS_C_CKP];
    wire dtp = ctrl_r[`UBWS_C_DTP];
    wire sync_tx_mode = sync_mode & clock_source_master & ~rx_any_en;

    // APB decode; an access completes in the second access-phase cycle.
    wire apb_done = psel & penable & pready;
    wire wr_en = apb_done & pwrite;
    wire rd_en = apb_done & ~pwrite;
    wire rd_rxd = rd_en & (paddr == `UBWS_OFF_RXD);
    wire wr_stat = wr_en & (paddr == `UBWS_OFF_STAT);
    wire wr_txd = wr_en & (paddr == `UBWS_OFF_TXD);
    wire addr_ok = (paddr == `UBWS_OFF_CTRL) | (paddr == `UBWS_OFF_STAT) |
                   (paddr == `UBWS_OFF_DIV) | (paddr == `UBWS_OFF_TXD) |
                   (paddr == `UBWS_OFF_RXD);

    // Receive line after synchronisation and data polarity.
    wire rx_lvl = pol(rx_pin_s, dtp);
    wire rx_fall = rx_prev_r & ~rx_lvl;
    wire rx_rise = ~rx_prev_r & rx_lvl;
    wire tx_busy = (tx_state_r != TX_IDLE);
    wire tx_load = ~tx_busy & txbuf_vld_r & transmit_enable & pen & ~brk_clr_r;

    ubws_sync u_rx_sync (
        .pclk(pclk),
        .presetn(presetn),
        .clk_en(clk_en),
        .async_in(rx_data_in),
        .sync_out(rx_pin_s)
    );

    // APB slave, control and divisor registers; hardware clears follow software writes.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= `UBWS_CTRL_RST;
            divisor_r <= `UBWS_DIV_RST;
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else if (clk_en) begin
            pready <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & ~addr_ok;
            if (psel & ~penable) begin
                case (paddr)
                    `UBWS_OFF_CTRL: prdata <= {21'h000000, ctrl_r};
                    `UBWS_OFF_STAT: prdata <= {26'h0000000, rx_state_r == RX_IDLE,
                        ~txbuf_vld_r, ~tx_busy, framing_error_flag_r, rx_pend_r, ab_ovf_r};
                    `UBWS_OFF_DIV: prdata <= {16'h0000, divisor_r};
                    `UBWS_OFF_RXD: prdata <= {24'h000000, rx_data_r};
                    default: prdata <= 32'h00000000;
                endcase
            end
            if (wr_en & (paddr == `UBWS_OFF_CTRL)) begin
                ctrl_r <= pwdata[`UBWS_CTRL_W-1:0];
            end
            if (wr_en & (paddr == `UBWS_OFF_DIV)) begin
                divisor_r <= pwdata[15:0];
            end
            if (ab_load_r) begin
                divisor_r <= ab_cnt_r[15:0];
            end
            if (ab_clr_r) begin
                ctrl_r[`UBWS_C_AUTOBAUD_ENABLE] <= 1'b0;
            end
            if (wue_clr_r) begin
                ctrl_r[`UBWS_C_WUE] <= 1'b0;
            end
            if (brk_clr_r) begin
                ctrl_r[`UBWS_C_BREAK_SEND_REQUEST] <= 1'b0;
            end
        end
    end

    // Transmit buffer and shifter, async frames and sync master clocking.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            txbuf_r <= 8'h00;
            txbuf_vld_r <= 1'b0;
            tx_state_r <= TX_IDLE;
            tx_cnt_r <= 16'h0000;
            tx_bits_r <= 4'h0;
            tsr_r <= 8'h00;
            tx_brk_r <= 1'b0;
            tx_line_r <= 1'b1;
            clk_act_r <= 1'b0;
            brk_clr_r <= 1'b0;
        end else if (clk_en) begin
            brk_clr_r <= 1'b0;
            if (!pen) begin
                txbuf_vld_r <= 1'b0;
                tx_state_r <= TX_IDLE;
                tx_line_r <= 1'b1;
                clk_act_r <= 1'b0;
            end else begin
                if (wr_txd) begin
                    txbuf_r <= pwdata[7:0];
                    txbuf_vld_r <= 1'b1;
                end else if (tx_load) begin
                    txbuf_vld_r <= 1'b0;
                end
                case (tx_state_r)
                    TX_IDLE: begin
                        tx_line_r <= sync_mode ? tx_line_r : 1'b1;
                        clk_act_r <= 1'b0;
                        tx_cnt_r <= 16'h0000;
                        tx_bits_r <= 4'h0;
                        if (tx_load && sync_mode) begin
                            if (sync_tx_mode) begin
                                tsr_r <= txbuf_r;
                                tx_state_r <= TX_SLEAD;
                            end
                        end else if (tx_load) begin
                            tx_brk_r <= break_send_request;
                            tsr_r <= break_send_request ? 8'h00 : txbuf_r;
                            tx_state_r <= TX_START;
                        end
                    end
                    TX_START: begin
                        tx_line_r <= 1'b0;
                        tx_cnt_r <= tx_cnt_r + 16'h0001;
                        if (bit_end(tx_cnt_r, divisor_r)) begin
                            tx_cnt_r <= 16'h0000;
                            tx_state_r <= TX_DATA;
                        end
                    end
                    TX_DATA: begin
                        tx_line_r <= tx_brk_r ? 1'b0 : tsr_r[0];
                        tx_cnt_r <= tx_cnt_r + 16'h0001;
                        if (bit_end(tx_cnt_r, divisor_r)) begin
                            tx_cnt_r <= 16'h0000;
                            tsr_r <= {1'b0, tsr_r[7:1]};
                            tx_bits_r <= tx_bits_r + 4'h1;
                            if (tx_bits_r == (tx_brk_r ? `UBWS_BRK_BITS - 4'h1 :
                                              `UBWS_DATA_BITS - 4'h1)) begin
                                tx_state_r <= TX_STOP;
                            end
                        end
                    end
                    TX_STOP: begin
                        tx_line_r <= 1'b1;
                        tx_cnt_r <= tx_cnt_r + 16'h0001;
                        if (bit_end(tx_cnt_r, divisor_r)) begin
                            brk_clr_r <= tx_brk_r;
                            tx_brk_r <= 1'b0;
                            tx_state_r <= TX_IDLE;
                        end
                    end
                    TX_SLEAD: begin
                        // Leading half: the bit is presented as the clock leaves idle.
                        clk_act_r <= 1'b1;
                        tx_line_r <= tsr_r[0];
                        tx_cnt_r <= tx_cnt_r + 16'h0001;
                        if (bit_end(tx_cnt_r, divisor_r)) begin
                            tx_cnt_r <= 16'h0000;
                            tx_state_r <= TX_STRAIL;
                        end
                    end
                    TX_STRAIL: begin
                        clk_act_r <= 1'b0;
                        tx_cnt_r <= tx_cnt_r + 16'h0001;
                        if (bit_end(tx_cnt_r, divisor_r)) begin
                            tx_cnt_r <= 16'h0000;
                            tsr_r <= {1'b0, tsr_r[7:1]};
                            tx_bits_r <= tx_bits_r + 4'h1;
                            if (tx_bits_r == `UBWS_DATA_BITS - 4'h1) begin
                                tx_state_r <= TX_IDLE;
                            end else begin
                                tx_state_r <= TX_SLEAD;
                            end
                        end
                    end
                    default: begin
                        tx_state_r <= TX_IDLE;
                    end
                endcase
            end
        end
    end

    // Receiver, wake-on-break and rate measurement, with the receive flags.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_state_r <= RX_IDLE;
            rx_cnt_r <= 16'h0000;
            rx_bits_r <= 4'h0;
            rsr_r <= 8'h00;
            rx_data_r <= 8'h00;
            rx_pend_r <= 1'b0;
            framing_error_flag_r <= 1'b0;
            ab_ovf_r <= 1'b0;
            ab_cnt_r <= 17'h00000;
            ab_pre_r <= 3'h0;
            ab_edges_r <= 3'h0;
            ab_load_r <= 1'b0;
            ab_clr_r <= 1'b0;
            wue_clr_r <= 1'b0;
            rx_prev_r <= 1'b1;
        end else if (clk_en) begin
            rx_prev_r <= rx_lvl;
            ab_load_r <= 1'b0;
            ab_clr_r <= 1'b0;
            wue_clr_r <= 1'b0;
            // Software clears; a hardware set later in this block wins.
            if (rd_rxd) begin
                rx_pend_r <= 1'b0;
            end
            if (wr_stat && !pwdata[`UBWS_S_ABOVF] && !autobaud_enable) begin
                ab_ovf_r <= 1'b0;
            end
            if (!pen || sync_mode) begin
                rx_state_r <= RX_IDLE;
            end else begin
                case (rx_state_r)
                    RX_IDLE: begin
                        rx_cnt_r <= 16'h0000;
                        rx_bits_r <= 4'h0;
                        if (wake_on_break_enable) begin
                            if (rx_fall) begin
                                rx_pend_r <= 1'b1;
                                rx_state_r <= RX_WAKE;
                            end
                        end else if (autobaud_enable) begin
                            if (rx_fall) begin
                                rx_state_r <= RX_ABWAIT;
                            end
                        end else if (ctrl_r[`UBWS_C_CONTINUOUS_RECEIVE_ENABLE] && rx_fall) begin
                            rx_state_r <= RX_START;
                        end
                    end
                    RX_WAKE: begin
                        // The whole low time, break or not, is the wake event.
                        if (rx_rise) begin
                            wue_clr_r <= 1'b1;
                            rx_state_r <= RX_IDLE;
                        end
                    end
                    RX_ABWAIT: begin
                        ab_cnt_r <= 17'h00001;
                        ab_pre_r <= 3'h0;
                        ab_edges_r <= 3'h1;
                        if (!autobaud_enable) begin
                            rx_state_r <= RX_IDLE;
                        end else if (rx_rise) begin
                            rx_state_r <= RX_ABCNT;
                        end
                    end
                    RX_ABCNT: begin
                        ab_pre_r <= ab_pre_r + 3'h1;
                        if (ab_pre_r == `UBWS_AB_PRE_LAST) begin
                            ab_cnt_r <= ab_cnt_r + 17'h00001;
                            if (ab_cnt_r[15:0] == 16'hFFFF) begin
                                ab_ovf_r <= 1'b1;
                            end
                        end
                        if (!autobaud_enable) begin
                            rx_state_r <= RX_IDLE;
                        end else if (rx_rise) begin
                            ab_edges_r <= ab_edges_r + 3'h1;
                            if (ab_edges_r == `UBWS_AB_EDGES - 3'h1) begin
                                ab_load_r <= 1'b1;
                                ab_clr_r <= 1'b1;
                                rx_pend_r <= 1'b1;
                                rx_state_r <= RX_IDLE;
                            end
                        end
                    end
                    RX_START: begin
                        rx_cnt_r <= rx_cnt_r + 16'h0001;
                        if (bit_end(rx_cnt_r, {1'b0, divisor_r[15:1]})) begin
                            rx_cnt_r <= 16'h0000;
                            rx_state_r <= rx_lvl ? RX_IDLE : RX_DATA;
                        end
                    end
                    RX_DATA: begin
                        rx_cnt_r <= rx_cnt_r + 16'h0001;
                        if (bit_end(rx_cnt_r, divisor_r)) begin
                            rx_cnt_r <= 16'h0000;
                            rsr_r <= {rx_lvl, rsr_r[7:1]};
                            rx_bits_r <= rx_bits_r + 4'h1;
                            if (rx_bits_r == `UBWS_DATA_BITS - 4'h1) begin
                                rx_state_r <= RX_STOP;
                            end
                        end
                    end
                    RX_STOP: begin
                        rx_cnt_r <= rx_cnt_r + 16'h0001;
                        if (bit_end(rx_cnt_r, divisor_r)) begin
                            rx_data_r <= rsr_r;
                            framing_error_flag_r <= ~rx_lvl;
                            rx_pend_r <= 1'b1;
                            rx_state_r <= RX_IDLE;
                        end
                    end
                    default: begin
                        rx_state_r <= RX_IDLE;
                    end
                endcase
            end
        end
    end

    // Pin drivers, registered from the shifter state.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_data_out <= 1'b0;
            rx_data_oe <= 1'b0;
            tx_clock_out <= 1'b1;
            tx_clock_oe <= 1'b0;
        end else if (clk_en) begin
            rx_data_out <= pol(tx_line_r, dtp);
            rx_data_oe <= pen & sync_tx_mode;
            if (sync_mode) begin
                tx_clock_out <= ckp ^ clk_act_r;
                tx_clock_oe <= pen & clock_source_master;
            end else begin
                tx_clock_out <= pol(tx_line_r, dtp);
                tx_clock_oe <= pen & transmit_enable;
            end
        end
    end
endmodule

//--- dv/ubws_chk.sv
// Purpose: Port-level checks for the serial port top.
// Assumes: clk_en is held high by the bench.
// Notes: Bound to ubws_top after the module.
`timescale 1ns/1ps
module ubws_chk (
    // Clock and reset.
    input wire pclk, presetn, clk_en,
    // APB side.
    input wire psel, penable, pwrite, pready, pslverr,
    input wire [7:0] paddr,
    input wire [31:0] pwdata, prdata,
    // Pin side.
    input wire rx_data_in, rx_data_out, rx_data_oe, tx_clock_out, tx_clock_oe
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Bus answers come one wait state in, for one cycle, and refusals read zero.
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready held two cycles");
    a_ready_wait: assert property (psel && penable && !$past(penable) |=> pready)
        else $error("pready not in second access cycle");
    a_ready_access: assert property (pready |-> psel && penable && $past(psel && penable))
        else $error("pready outside an access");
    a_err_unmapped: assert property (pready && paddr > 8'h10 |-> pslverr)
        else $error("unmapped address not refused");
    a_err_rzero: assert property (pslverr && !pwrite |-> prdata == 32'h0)
        else $error("refused read returned data");
    a_rdata_hold: assert property (psel && penable && $past(psel && penable) |-> $stable(prdata))
        else $error("read data moved during access");
    // The master drives the clock whenever it drives data.
    a_oe_pair: assert property (rx_data_oe |-> tx_clock_oe)
        else $error("data driven without clock driver");
    // Data may only move together with a clock edge.
    a_data_lead: assert property (rx_data_oe && $past(rx_data_oe) && $changed(rx_data_out)
        |-> $changed(tx_clock_out))
        else $error("data changed away from a clock edge");
endmodule
bind ubws_top ubws_chk ubws_chk_i (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready), .pslverr(pslverr),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .rx_data_in(rx_data_in),
    .rx_data_out(rx_data_out), .rx_data_oe(rx_data_oe), .tx_clock_out(tx_clock_out),
    .tx_clock_oe(tx_clock_oe));

//--- dv/ubws_node.sv
// Purpose: Remote node: async sender and sync slave receiver.
// Assumes: One async bit time is 25 pclk cycles, 125 ns.
// Notes: The line idles high as if pulled up.
`timescale 1ns/1ps
module ubws_node (
    // Clock.
    input wire logic pclk,
    // Sync master outputs and the chosen clock idle level.
    input wire logic sck, sdat, soe, ckp,
    // Line toward the block.
    output logic line
);
    logic sck_q;
    logic [7:0] got;
    int n;
    initial begin
        line = 1'b1;
        got = 8'h00;
        n = 0;
        sck_q = 1'b0;
    end
    // Shift in on the trailing edge, where the clock returns to idle.
    always @(posedge pclk) begin
        sck_q <= sck;
        if (soe && sck !== sck_q && sck === ckp) begin
            got <= {sdat, got[7:1]};
            n <= n + 1;
        end
    end
    // Send k bits LSB first, then release the line high; callers keep breaks long.
    task send(input logic [15:0] b, input int k);
        for (int i = 0; i < k; i++) begin
            line <= b[i];
            repeat (25) @(posedge pclk);
        end
        line <= 1'b1;
    endtask
endmodule

//--- dv/tb.sv
// Purpose: Self-checking bench for the serial port top.
// Assumes: APB master with one idle cycle between transfers.
// Notes: Reset checks run first, then sync rows, then hand-written cases.
`timescale 1ns/1ps
`include "ubws_regs.vh"
module tb;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, line, ckp;
    logic rx_data_in, rx_data_out, rx_data_oe, tx_clock_out, tx_clock_oe;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [26:0] rows [0:2];
    int errors, n_checks, n0, c;
    // The data pin carries the block while it drives, else the node.
    assign rx_data_in = rx_data_oe ? rx_data_out : line;
    ubws_top ubws_top_i (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rx_data_in(rx_data_in), .rx_data_out(rx_data_out),
        .rx_data_oe(rx_data_oe), .tx_clock_out(tx_clock_out), .tx_clock_oe(tx_clock_oe));
    ubws_node ubws_node_i (.pclk(pclk), .sck(tx_clock_out), .sdat(rx_data_out),
        .soe(rx_data_oe), .ckp(ckp), .line(line));
    // Clock at 200 MHz.
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    // Compare and count.
    task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // One APB transfer; read data and error are taken where pready is high.
    task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Length in cycles of the next low run on the async transmit line.
    task lowrun;
        c = 0;
        while (tx_clock_out !== 1'b0) @(negedge pclk);
        while (tx_clock_out === 1'b0) begin
            c++;
            @(negedge pclk);
        end
    endtask
    task final_report;
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // Watchdog: the run needs about 3k cycles, this allows 60k.
    initial begin
        #300000;
        errors++;
        final_report;
    end
    // Main sequence.
    initial begin
        {psel, penable, pwrite, paddr, pwdata, presetn, ckp, errors, n_checks} = '0;
        rows[0] = {11'h00F, 8'hA5, 8'hA5};
        rows[1] = {11'h20F, 8'h3C, 8'h3C};
        rows[2] = {11'h40F, 8'h96, 8'h69};
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(negedge pclk);
        chk("txc", tx_clock_out, 32'h1);
        chk("txoe", tx_clock_oe, 32'h0);
        apb(`UBWS_OFF_CTRL, 1'b0, 32'h0);
        chk("ctrl", rd, 32'h0);
        apb(`UBWS_OFF_DIV, 1'b0, 32'h0);
        chk("div", rd, 32'hF);
        apb(8'h14, 1'b0, 32'h0);
        chk("err", err, 32'h1);
        $display("done reset");
        // Sync master transmit: polarity rows, bits seen by the slave.
        for (int i = 0; i < 3; i++) begin
            ckp <= rows[i][25];
            apb(`UBWS_OFF_CTRL, 1'b1, rows[i][26:16]);
            repeat (3) @(posedge pclk);
            n0 = ubws_node_i.n;
            apb(`UBWS_OFF_TXD, 1'b1, rows[i][15:8]);
            while (ubws_node_i.n < n0 + 8) @(posedge pclk);
            repeat (80) @(posedge pclk);
            chk("bits", ubws_node_i.n - n0, 32'h8);
            chk("byte", ubws_node_i.got, rows[i][7:0]);
            chk("idle", tx_clock_out, ckp);
            chk("ckoe", tx_clock_oe, 32'h1);
        end
        $display("done sync rows");
        // Receive enable set: the master must not shift out.
        apb(`UBWS_OFF_CTRL, 1'b1, 32'h04F);
        apb(`UBWS_OFF_TXD, 1'b1, 32'hA5);
        repeat (400) @(posedge pclk);
        chk("rxoe", rx_data_oe, 32'h0);
        // Break with ignored data, then the buffered sync byte.
        apb(`UBWS_OFF_DIV, 1'b1, 32'h18);
        apb(`UBWS_OFF_CTRL, 1'b1, 32'h019);
        repeat (2) @(posedge pclk);
        fork
            lowrun;
            begin
                apb(`UBWS_OFF_TXD, 1'b1, 32'hFF);
                apb(`UBWS_OFF_TXD, 1'b1, 32'h55);
            end
        join
        chk("brk", c, 32'd325);
        lowrun;
        chk("sync", c, 32'd25);
        apb(`UBWS_OFF_CTRL, 1'b0, 32'h0);
        chk("break_send_request", rd[4], 32'h0);
        $display("done break");
        // Rate measurement on a 55h byte at 25 cycles a bit.
        apb(`UBWS_OFF_CTRL, 1'b1, 32'h101);
        ubws_node_i.send(16'h2AA, 10);
        repeat (10) @(posedge pclk);
        apb(`UBWS_OFF_DIV, 1'b0, 32'h0);
        chk("abd", rd >= 25 && rd <= 27, 32'h1);
        apb(`UBWS_OFF_CTRL, 1'b0, 32'h0);
        chk("autobaud_enable", rd[8], 32'h0);
        apb(`UBWS_OFF_RXD, 1'b0, 32'h0);
        apb(`UBWS_OFF_STAT, 1'b0, 32'h0);
        chk("pend", rd[1], 32'h0);
        chk("ovf", rd[0], 32'h0);
        $display("done autobaud");
        // Wake on break: pending during the break, enable clears after it.
        apb(`UBWS_OFF_CTRL, 1'b1, 32'h081);
        fork
            ubws_node_i.send(16'h0, 13);
            begin
                repeat (150) @(posedge pclk);
                apb(`UBWS_OFF_STAT, 1'b0, 32'h0);
                chk("wpend", rd[1], 32'h1);
            end
        join
        repeat (20) @(posedge pclk);
        apb(`UBWS_OFF_CTRL, 1'b0, 32'h0);
        chk("wue", rd[7], 32'h0);
        apb(`UBWS_OFF_RXD, 1'b0, 32'h0);
        // A break seen by normal reception.
        apb(`UBWS_OFF_CTRL, 1'b1, 32'h041);
        ubws_node_i.send(16'h0, 13);
        repeat (40) @(posedge pclk);
        apb(`UBWS_OFF_STAT, 1'b0, 32'h0);
        chk("rbrk", rd[2:1], 32'h3);
        apb(`UBWS_OFF_RXD, 1'b0, 32'h0);
        chk("rdat", rd, 32'h0);
        $display("done wake and break receive");
        final_report;
    end
endmodule
